// ### logic/csioc_map.svh
// register offsets, field positions and reset values of the serial channel block
`ifndef CSIOC_MAP_SVH
`define CSIOC_MAP_SVH
`define CSIOC_OFF_DIV 8'h00
`define CSIOC_OFF_LVL 8'h04
`define CSIOC_OFF_OE 8'h08
`define CSIOC_OFF_P5DIR 8'h0C
`define CSIOC_OFF_P5OUT 8'h10
`define CSIOC_OFF_P3OUT 8'h14
`define CSIOC_OFF_P3DIR 8'h18
`define CSIOC_OFF_IFLAG 8'h1C
`define CSIOC_OFF_IMASK 8'h20
`define CSIOC_OFF_START 8'h24
`define CSIOC_OFF_STAT 8'h28
`define CSIOC_OFF_CTRL 8'h2C
`define CSIOC_DIV_LSB 9
`define CSIOC_CLK_LVL_LSB 8
`define CSIOC_IRQ_BIT 5
`define CSIOC_BUSY_BIT 4
`define CSIOC_RST_DIV 7'h00
`define CSIOC_RST_LVL 4'hF
`define CSIOC_RST_OE 4'h0
`define CSIOC_RST_PDIR 8'hFF
`define CSIOC_RST_P3DIR 2'h3
`define CSIOC_RST_POUT 8'h00
`define CSIOC_RST_MASK 1'b1
`define CSIOC_BITS_PER_XFER 4'h8
`endif

// ### logic/csioc_pkg.sv
// types shared by the serial channel block
package csioc_pkg;
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAIT,
        ST_SHIFT
    } csioc_state_t;
    typedef logic [7:0] csioc_byte_t;
endpackage

// ### logic/csioc_top.sv
// channel 0 three-wire serial master: setup, pins, interrupt and start control
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "csioc_map.svh"

module csioc_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // data-in pin
    input wire logic data_in_pin_in,
    output logic data_in_pin_out,
    output logic data_in_pin_oe,
    // data-out pin
    output logic data_out_pin_out,
    output logic data_out_pin_oe,
    // clock pin
    output logic clock_pin_out,
    output logic clock_pin_oe,
    // interrupt
    output logic irq
);
    logic [6:0] div_n_reg;
    csioc_pkg::csioc_byte_t data_reg;
    logic [3:0] lvl_clk_reg;
    logic [3:0] lvl_dat_reg;
    logic [3:0] out_en_reg;
    logic [7:0] p5_dir_reg;
    logic [7:0] p5_out_reg;
    logic [1:0] p3_dir_reg;
    logic [1:0] p3_out_reg;
    logic irq_flag_reg;
    logic irq_mask_reg;
    logic [3:0] en_stat_reg;
    logic src_sel_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;
    csioc_pkg::csioc_state_t state_reg;
    logic [6:0] div_cnt_reg;
    logic [3:0] bit_cnt_reg;
    csioc_pkg::csioc_byte_t sh_reg;
    logic sclk_reg;
    logic sdo_reg;
    logic [6:0] hold_reg;
    logic [3:0] fall_cnt_reg;
    logic [31:0] rd_val;
    logic hit;
    logic sclk_next;
    logic sdo_next;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    wire acc = psel && penable;
    wire wr = acc && pwrite && pready;
    wire wr_div = wr && paddr == `CSIOC_OFF_DIV;
    wire wr_lvl = wr && paddr == `CSIOC_OFF_LVL;
    wire wr_start = wr && paddr == `CSIOC_OFF_START;
    wire tx_go = wr_div && state_reg == csioc_pkg::ST_WAIT;
    wire tick = state_reg == csioc_pkg::ST_SHIFT && div_cnt_reg == div_n_reg;
    wire done = tick && !sclk_reg && bit_cnt_reg == `CSIOC_BITS_PER_XFER - 4'h1;
    wire irq_ev = src_sel_reg ? tx_go : done;

    // register read mux; reserved and unallocated bits read as zero, except P3DIR bits 7:2, which read as ones
    always_comb begin
        rd_val = 32'h0000_0000;
        hit = 1'b1;
        case (paddr)
            `CSIOC_OFF_DIV: rd_val[15:0] = {div_n_reg, 1'b0, data_reg};
            `CSIOC_OFF_LVL: rd_val[11:0] = {lvl_clk_reg, 4'h0, lvl_dat_reg};
            `CSIOC_OFF_OE: rd_val[3:0] = out_en_reg;
            `CSIOC_OFF_P5DIR: rd_val[7:0] = p5_dir_reg;
            `CSIOC_OFF_P5OUT: begin
                // bit 0 in input mode reads the data-in pin, not the latch; bits 7:1 always read the latch
                rd_val[7:0] = {p5_out_reg[7:1], p5_dir_reg[0] ? sdi_s2_reg : p5_out_reg[0]};
            end
            `CSIOC_OFF_P3OUT: rd_val[1:0] = p3_out_reg;
            `CSIOC_OFF_P3DIR: rd_val[7:0] = {6'h3F, p3_dir_reg};
            `CSIOC_OFF_IFLAG: rd_val[`CSIOC_IRQ_BIT] = irq_flag_reg;
            `CSIOC_OFF_IMASK: rd_val[`CSIOC_IRQ_BIT] = irq_mask_reg;
            `CSIOC_OFF_START: rd_val = 32'h0000_0000;
            `CSIOC_OFF_STAT: begin
                rd_val[3:0] = en_stat_reg;
                rd_val[`CSIOC_BUSY_BIT] = state_reg == csioc_pkg::ST_SHIFT;
            end
            `CSIOC_OFF_CTRL: rd_val[0] = src_sel_reg;
            default: hit = 1'b0;
        endcase
    end

    // one wait state so read data and ready both leave flip-flops
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc && !pready;
            if (acc && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
                pslverr <= !hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    apb_answer_a: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("apb access not answered after one wait state");
    slverr_pair_a: assert property (pslverr |-> pready)
        else $error("slave error raised outside the answer cycle");

    // divider and data register; the divider is frozen while shifting
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_n_reg <= `CSIOC_RST_DIV;
            data_reg <= 8'h00;
        end else if (done) begin
            data_reg <= {sh_reg[6:0], sdi_s2_reg};
        end else if (wr_div && state_reg != csioc_pkg::ST_SHIFT) begin
            div_n_reg <= pwdata[`CSIOC_DIV_LSB +: 7];
            data_reg <= pwdata[7:0];
        end
    end

    // a write while shifting must not upset the running clock or the byte
    div_frozen_a: assert property (wr_div && state_reg == csioc_pkg::ST_SHIFT |=>
        $stable(div_n_reg))
        else $error("divider changed while shifting");
    shift_refuse_a: assert property (wr_div && !done &&
        state_reg == csioc_pkg::ST_SHIFT |=> $stable(data_reg))
        else $error("data register written while shifting");

    // channel 0 level bits belong to the shifter while its output is enabled
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            lvl_clk_reg <= `CSIOC_RST_LVL;
            lvl_dat_reg <= `CSIOC_RST_LVL;
        end else begin
            if (wr_lvl) begin
                lvl_clk_reg[3:1] <= pwdata[11:9];
                lvl_dat_reg[3:1] <= pwdata[3:1];
            end
            if (out_en_reg[0] && state_reg == csioc_pkg::ST_SHIFT) begin
                lvl_clk_reg[0] <= sclk_next;
                lvl_dat_reg[0] <= sdo_next;
            end else if (wr_lvl && !out_en_reg[0]) begin
                lvl_clk_reg[0] <= pwdata[`CSIOC_CLK_LVL_LSB];
                lvl_dat_reg[0] <= pwdata[0];
            end
        end
    end

    hold_off_a: assert property (!out_en_reg[0] && !wr_lvl |=> $stable(lvl_clk_reg[0]))
        else $error("clock level moved with serial output disabled");
    data_hold_a: assert property (!out_en_reg[0] && !wr_lvl |=> $stable(lvl_dat_reg[0]))
        else $error("data level moved with serial output disabled");
    level_write_a: assert property (wr_lvl && !out_en_reg[0] |=>
        lvl_dat_reg[0] == $past(pwdata[0]) && lvl_clk_reg[0] == $past(pwdata[8]))
        else $error("level write not taken");

    // output enable, port latches, directions, source select, start status
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            out_en_reg <= `CSIOC_RST_OE;
            p5_dir_reg <= `CSIOC_RST_PDIR;
            p5_out_reg <= `CSIOC_RST_POUT;
            p3_dir_reg <= `CSIOC_RST_P3DIR;
            p3_out_reg <= 2'h0;
            src_sel_reg <= 1'b0;
            en_stat_reg <= 4'h0;
        end else if (wr) begin
            unique case (paddr)
                `CSIOC_OFF_OE: out_en_reg <= pwdata[3:0];
                `CSIOC_OFF_P5DIR: p5_dir_reg <= pwdata[7:0];
                `CSIOC_OFF_P5OUT: p5_out_reg <= pwdata[7:0];
                `CSIOC_OFF_P3DIR: p3_dir_reg <= pwdata[1:0];
                `CSIOC_OFF_P3OUT: p3_out_reg <= pwdata[1:0];
                `CSIOC_OFF_CTRL: src_sel_reg <= pwdata[0];
                // ones set, zeros leave the bit alone
                `CSIOC_OFF_START: en_stat_reg <= en_stat_reg | pwdata[3:0];
                default: ;
            endcase
        end
    end

    start_set_a: assert property (wr_start && pwdata[0] |=> en_stat_reg[0])
        else $error("start trigger did not set enable status");
    start_zero_a: assert property (wr_start && !pwdata[0] |=> $stable(en_stat_reg[0]))
        else $error("writing zero to start changed status");
    wait_entry_a: assert property (state_reg == csioc_pkg::ST_OFF && en_stat_reg[0] |=>
        state_reg == csioc_pkg::ST_WAIT)
        else $error("started channel did not enter wait");
    start_keep_a: assert property (en_stat_reg[0] |=> en_stat_reg[0])
        else $error("enable status dropped without reset");

    // two flops before the data-in pin reaches any logic
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
        end else begin
            sdi_s1_reg <= data_in_pin_in;
            sdi_s2_reg <= sdi_s1_reg;
        end
    end

    always_comb begin
        sclk_next = tick ? !sclk_reg : sclk_reg;
        sdo_next = (tick && sclk_reg) ? sh_reg[7] : sdo_reg;
    end

    // channel state: off until started, then wait, shift, wait
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= csioc_pkg::ST_OFF;
        end else begin
            unique case (state_reg)
                csioc_pkg::ST_OFF: if (en_stat_reg[0]) state_reg <= csioc_pkg::ST_WAIT;
                csioc_pkg::ST_WAIT: if (tx_go) state_reg <= csioc_pkg::ST_SHIFT;
                csioc_pkg::ST_SHIFT: if (done) state_reg <= csioc_pkg::ST_WAIT;
                default: state_reg <= csioc_pkg::ST_OFF;
            endcase
        end
    end

    // divider: half period of the transfer clock is N+1 operating clocks
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_cnt_reg <= 7'h00;
        end else if (state_reg != csioc_pkg::ST_SHIFT || tick) begin
            div_cnt_reg <= 7'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 7'h01;
        end
    end

    // clock idles high; data leaves on the falling edge, MSB first, and is
    // sampled on the rising edge, so the eighth rise closes the byte
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_reg <= 1'b1;
            sdo_reg <= 1'b1;
            sh_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
        end else if (tx_go) begin
            sclk_reg <= 1'b1;
            sh_reg <= pwdata[7:0];
            bit_cnt_reg <= 4'h0;
        end else if (tick) begin
            sclk_reg <= sclk_next;
            sdo_reg <= sdo_next;
            if (!sclk_reg) begin
                sh_reg <= {sh_reg[6:0], sdi_s2_reg};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // helper counts for checks: clock half-period length and falling edges
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hold_reg <= 7'h00;
            fall_cnt_reg <= 4'h0;
        end else if (tx_go) begin
            hold_reg <= 7'h00;
            fall_cnt_reg <= 4'h0;
        end else begin
            hold_reg <= tick ? 7'h00 : hold_reg + 7'h01;
            if (tick && sclk_reg) begin
                fall_cnt_reg <= fall_cnt_reg + 4'h1;
            end
        end
    end

    sequence xfer_launch;
        tx_go ##1 state_reg == csioc_pkg::ST_SHIFT;
    endsequence
    sequence xfer_close;
        done ##1 state_reg == csioc_pkg::ST_WAIT && sclk_reg;
    endsequence
    half_period_a: assert property (tick |-> hold_reg == div_n_reg)
        else $error("transfer clock half period not N+1 cycles");
    launch_a: assert property (state_reg == csioc_pkg::ST_WAIT && wr_div |-> xfer_launch)
        else $error("data write in wait did not start shifting");
    eight_pulses_a: assert property (done |-> fall_cnt_reg == 4'h8 ##0 xfer_close)
        else $error("transfer did not end after eight clock pulses");
    idle_high_a: assert property (state_reg != csioc_pkg::ST_SHIFT |-> sclk_reg)
        else $error("transfer clock not idling high");

    // request flag: the event wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq_flag_reg <= 1'b0;
            irq_mask_reg <= `CSIOC_RST_MASK;
            irq <= 1'b0;
        end else begin
            if (irq_ev) begin
                irq_flag_reg <= 1'b1;
            end else if (wr && paddr == `CSIOC_OFF_IFLAG && pwdata[`CSIOC_IRQ_BIT]) begin
                irq_flag_reg <= 1'b0;
            end
            if (wr && paddr == `CSIOC_OFF_IMASK) begin
                irq_mask_reg <= pwdata[`CSIOC_IRQ_BIT];
            end
            irq <= irq_flag_reg && !irq_mask_reg;
        end
    end

    src_empty_a: assert property (src_sel_reg && tx_go |=> irq_flag_reg)
        else $error("buffer empty did not raise the request");
    src_end_a: assert property (!src_sel_reg && done |=> irq_flag_reg)
        else $error("transfer end did not raise the request");
    irq_gate_a: assert property (irq_flag_reg && irq_mask_reg |=> !irq)
        else $error("masked request reached the interrupt");
    irq_pass_a: assert property (irq_flag_reg && !irq_mask_reg |=> irq)
        else $error("unmasked request did not reach the interrupt");
    // a clear with no event in the same cycle must take
    flag_clear_a: assert property (wr && paddr == `CSIOC_OFF_IFLAG && !irq_ev &&
        pwdata[`CSIOC_IRQ_BIT] |=> !irq_flag_reg)
        else $error("write one did not clear the request");

    // pins: latch and serial level combine on the clock and data-out pins, data-in takes the latch alone; direction 0 turns the buffer on
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            data_in_pin_out <= 1'b0;
            data_in_pin_oe <= 1'b0;
            data_out_pin_out <= 1'b0;
            data_out_pin_oe <= 1'b0;
            clock_pin_out <= 1'b0;
            clock_pin_oe <= 1'b0;
        end else begin
            data_in_pin_out <= p5_out_reg[0];
            data_in_pin_oe <= !p5_dir_reg[0];
            data_out_pin_out <= p5_out_reg[1] && lvl_dat_reg[0];
            data_out_pin_oe <= !p5_dir_reg[1];
            clock_pin_out <= p3_out_reg[0] && lvl_clk_reg[0];
            clock_pin_oe <= !p3_dir_reg[0];
        end
    end

    pin_dir_a: assert property ($fell(p3_dir_reg[0]) |=> clock_pin_oe ##1 clock_pin_oe)
        else $error("clock pin buffer not on in output mode");
    // the pin follows latch and level one cycle later, whatever moved them
    pin_level_a: assert property (p3_out_reg[0] && lvl_clk_reg[0] |=> clock_pin_out)
        else $error("clock pin not at latched idle level");
    data_pin_a: assert property (p5_out_reg[1] && lvl_dat_reg[0] |=> data_out_pin_out)
        else $error("data pin not at latched level");
    data_oe_a: assert property (!p5_dir_reg[1] |=> data_out_pin_oe)
        else $error("data-out pin buffer not on in output mode");
    in_oe_a: assert property (p5_dir_reg[0] |=> !data_in_pin_oe)
        else $error("data-in pin buffer on in input mode");
endmodule // csioc_top

// ### tb/csioc_slave.sv
// clocked serial slave model on the far side of the three-wire link
`timescale 1ns/1ns
module csioc_slave (
    // link
    input wire logic sclk,
    input wire logic sdo,
    output logic sdi,
    // byte side
    input wire logic frame_start,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] sh;
    int bits;
    initial begin
        sdi = 1'b0;
        bits = 0;
        rx_byte = 8'h00;
    end
    // data changes on the falling clock, msb first
    always @(negedge sclk) begin
        if (bits == 0) begin
            sh = tx_byte;
        end
        sdi <= sh[7];
        sh = {sh[6:0], 1'b0};
    end
    // sampled on the rise; after the last bit the line stops holding data;
    // the link has no select, so the bench marks each frame to realign the count
    always @(posedge sclk or posedge frame_start) begin
        if (frame_start) begin
            bits = 0;
        end else begin
            rx_byte <= {rx_byte[6:0], sdo};
            bits = (bits == 7) ? 0 : bits + 1;
            if (bits == 0) begin
                sdi <= ~sdi;
            end
        end
    end
endmodule // csioc_slave

// ### tb/tb_top.sv
// register-level testbench of the serial channel setup and start block
`timescale 1ns/1ns
`include "csioc_map.svh"
module tb_top;
    logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, irq, err, ck_prev;
    logic di_out, di_oe, do_out, do_oe, ck_out, ck_oe, sdi, sclk_w, sdo_w, di_w, frame_start;
    logic [7:0] paddr, stx, srx;
    logic [31:0] pwdata, prdata, q;
    int bad_count, checks, falls, t0, t1, cyc, n;
    // released clock and data-out lines are pulled up; a released data-in line carries the slave's sdi
    assign sclk_w = ck_oe ? ck_out : 1'b1;
    assign sdo_w = do_oe ? do_out : 1'b1;
    assign di_w = di_oe ? di_out : sdi;
    csioc_top u_csioc_top (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_in_pin_in(di_w), .data_in_pin_out(di_out),
        .data_in_pin_oe(di_oe), .data_out_pin_out(do_out), .data_out_pin_oe(do_oe),
        .clock_pin_out(ck_out), .clock_pin_oe(ck_oe), .irq(irq));
    csioc_slave u_csioc_slave (.sclk(sclk_w), .sdo(sdo_w), .sdi(sdi),
        .frame_start(frame_start), .tx_byte(stx), .rx_byte(srx));
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    // falling clock edges seen on the pin, timed in reference cycles
    always @(posedge ref_clk) begin
        if (ck_prev === 1'b1 && sclk_w === 1'b0) begin
            if (falls == 0) begin
                t0 = cyc;
            end
            t1 = cyc;
            falls++;
        end
        ck_prev <= sclk_w;
        cyc++;
    end
    task automatic complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic settle(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // one byte: the divider write starts it, a second write while shifting is ignored
    task automatic xfer(input logic [6:0] nn, input logic [7:0] d, input logic [31:0] fl);
        falls = 0;
        frame_start <= 1'b1;
        settle(1);
        frame_start <= 1'b0;
        wr(`CSIOC_OFF_DIV, {16'h0, nn, 1'b0, d});
        rd(`CSIOC_OFF_STAT, 32'h11);
        wr(`CSIOC_OFF_DIV, 32'h0000_00FF);
        rd(`CSIOC_OFF_IFLAG, fl);
        n = 0;
        do begin
            apb(1'b0, `CSIOC_OFF_STAT, 32'h0);
            n++;
        end while (q[4] !== 1'b0 && n < 3000);
        chk(q, 32'h1);
        settle(4);
        chk(falls, 8);
        chk(t1 - t0, 7 * 2 * (nn + 1));
        rd(`CSIOC_OFF_DIV, {16'h0, nn, 1'b0, stx});
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        bad_count++;
        complete_run;
    end
    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stx = 8'h3C;
        frame_start = 1'b0;
        bad_count = 0;
        checks = 0;
        falls = 0;
        cyc = 0;
        repeat (4) @(posedge ref_clk);
        chk({ck_oe, do_oe, di_oe}, 32'h0);
        nrst <= 1'b1;
        rd(`CSIOC_OFF_DIV, 32'h0);
        rd(`CSIOC_OFF_LVL, 32'h0F0F);
        rd(`CSIOC_OFF_OE, 32'h0);
        rd(`CSIOC_OFF_P5DIR, 32'hFF);
        rd(`CSIOC_OFF_P5OUT, 32'h0);
        rd(`CSIOC_OFF_P3DIR, 32'hFF);
        rd(`CSIOC_OFF_IFLAG, 32'h0);
        rd(`CSIOC_OFF_IMASK, 32'h20);
        rd(`CSIOC_OFF_STAT, 32'h0);
        apb(1'b0, 8'h30, 32'h0);
        chk(err, 32'h1);
        chk(q, 32'h0);
        wr(`CSIOC_OFF_LVL, 32'hFFFF_FFFF);
        rd(`CSIOC_OFF_LVL, 32'h0F0F);
        wr(`CSIOC_OFF_OE, 32'hFFFF_FFFF);
        rd(`CSIOC_OFF_OE, 32'hF);
        wr(`CSIOC_OFF_OE, 32'h0);
        // latches high before the pins turn to outputs
        wr(`CSIOC_OFF_P5OUT, 32'h02);
        wr(`CSIOC_OFF_P3OUT, 32'h01);
        wr(`CSIOC_OFF_P5DIR, 32'hFD);
        wr(`CSIOC_OFF_P3DIR, 32'h02);
        rd(`CSIOC_OFF_P3DIR, 32'hFE);
        settle(3);
        chk({di_oe, do_oe, ck_oe, do_out, ck_out}, 32'h0F);
        for (int i = 0; i < 2; i++) begin
            wr(`CSIOC_OFF_LVL, i ? 32'h0F0F : 32'h0E0E);
            settle(3);
            chk({ck_out, do_out}, i ? 32'h3 : 32'h0);
        end
        wr(`CSIOC_OFF_P3OUT, 32'h0);
        settle(3);
        chk(ck_out, 32'h0);
        wr(`CSIOC_OFF_P3OUT, 32'h1);
        wr(`CSIOC_OFF_P5DIR, 32'hFC);
        wr(`CSIOC_OFF_P5OUT, 32'h03);
        settle(3);
        chk({di_oe, di_out}, 32'h3);
        wr(`CSIOC_OFF_P5DIR, 32'hFD);
        wr(`CSIOC_OFF_P5OUT, 32'h02);
        wr(`CSIOC_OFF_IFLAG, 32'h20);
        wr(`CSIOC_OFF_OE, 32'h1);
        wr(`CSIOC_OFF_LVL, 32'h0);
        rd(`CSIOC_OFF_LVL, 32'h0101);
        settle(3);
        chk({ck_out, do_out}, 32'h3);
        wr(`CSIOC_OFF_START, 32'h0);
        rd(`CSIOC_OFF_STAT, 32'h0);
        wr(`CSIOC_OFF_START, 32'h1);
        rd(`CSIOC_OFF_START, 32'h0);
        rd(`CSIOC_OFF_STAT, 32'h1);
        xfer(7'd103, 8'hA5, 32'h0);
        chk(srx, 32'hA5);
        rd(`CSIOC_OFF_IFLAG, 32'h20);
        chk(irq, 32'h0);
        wr(`CSIOC_OFF_IFLAG, 32'h20);
        rd(`CSIOC_OFF_IFLAG, 32'h0);
        // buffer-empty source, unmasked
        stx = 8'hC3;
        wr(`CSIOC_OFF_CTRL, 32'h1);
        wr(`CSIOC_OFF_IMASK, 32'h0);
        xfer(7'd4, 8'h5A, 32'h20);
        chk(srx, 32'h5A);
        chk(irq, 32'h1);
        wr(`CSIOC_OFF_IFLAG, 32'h20);
        settle(3);
        chk(irq, 32'h0);
        complete_run;
    end
endmodule // tb_top
